/* File: rtl/cgp_pkg.sv */
package cgp_pkg;
    // Byte-1 register selectors of the control instruction (address field).
    localparam logic [7:0] SEL_TX_SLOT = 8'h0_0;
    localparam logic [7:0] SEL_RX_SLOT = 8'h0_1;
    localparam logic [7:0] SEL_TX_GAIN = 8'h0_2;
    localparam logic [7:0] SEL_RX_GAIN = 8'h0_3;
    localparam logic [7:0] SEL_ECHO_CTRL = 8'h0_4;
    localparam logic [7:0] SEL_BIQUAD = 8'h0_5;
    localparam logic [7:0] SEL_HIGHBAND = 8'h0_6;

    // Time-slot byte 2 field positions.
    localparam int SLOT_EN_BIT = 7;
    localparam int SLOT_PS_BIT = 6;
    localparam int SLOT_NUM_MSB = 5;

    // Echo-cancel control byte 2 field positions.
    localparam int ECHO_EN_BIT = 7;
    localparam int ECHO_PHASE_BIT = 6;
    localparam int ECHO_HB_BIT = 5;
    localparam int ECHO_ATTEN_MSB = 4;
    localparam logic [4:0] ATTEN_MAX_CODE = 5'h1_8;

    // Biquad register: mode bit selects first-order operation.
    localparam int BIQUAD_MODE_BIT = 7;
    localparam int BIQUAD_CODE_MSB = 6;

    // Highband register: pole code in the upper nibble, zero code in the lower.
    localparam int HB_POLE_MSB = 7;
    localparam int HB_POLE_LSB = 4;
    localparam int HB_ZERO_MSB = 3;

    // Gain step of one code increment, in hundredths of a decibel.
    localparam int GAIN_STEP_CDB = 10;

    // Values after reset: all ports disabled, gains at no output, hybrid off.
    localparam logic [7:0] RST_SLOT = 8'h0_0;
    localparam logic [7:0] RST_GAIN = 8'h0_0;
    localparam logic [7:0] RST_ECHO = 8'h0_0;
    localparam logic [7:0] RST_BIQUAD = 8'h0_0;
    localparam logic [7:0] RST_HIGHBAND = 8'h0_0;
    localparam logic [7:0] ZERO_BYTE = 8'h0_0;
endpackage : cgp_pkg

/* File: rtl/cgp_config.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Two tx and two rx PCM ports; port select bit picks the active one.
// - Transmit gain is an 8-bit code, one tenth dB per step.
// - Receive gain is an 8-bit code, one tenth dB per step.
// - Zero receive gain mutes analog output; decoding still runs.
// - Echo control bit 7 enables cancellation; zero removes it entirely.
// - Echo control bit 6 picks cancellation phase: zero inverted, one not.
// - Echo control bit 5 enables the highband first-order section.
// - Five low bits set attenuation, 00000 is -2.5 dB, 11000 is -8.5 dB.
// - Chain is biquad, then highband section, then attenuator; sections bypassable.
// - Biquad may run first-order with a real pole, zero at 0 Hz, coded.
// - Highband section has independently programmed pole and zero codes.
// - Biquad register selects section, mode and code; all zero bypasses it.
// - After reset the hybrid balance filter is disabled until programmed.
module cgp_config (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic instr_write,
    input wire logic instr_read,
    input wire logic [7:0] instr_select,
    input wire logic [7:0] instr_data,
    output logic [7:0] read_data,
    output logic read_valid,
    input wire logic pcm_tx_bit,
    output logic pcm_tx_port_a,
    output logic pcm_tx_port_a_oe,
    output logic pcm_tx_port_b,
    output logic pcm_tx_port_b_oe,
    input wire logic pcm_rx_port_a,
    input wire logic pcm_rx_port_b,
    output logic pcm_rx_bit,
    output logic pcm_rx_active,
    output logic [5:0] tx_slot_number,
    output logic [5:0] rx_slot_number,
    output logic [7:0] transmit_gain_code,
    output logic [7:0] receive_gain_code,
    output logic analog_rx_output_enable,
    output logic decoder_run,
    output logic cancel_enable,
    output logic cancel_phase_noninvert,
    output logic highband_enable,
    output logic [4:0] cancel_atten_field,
    output logic biquad_enable,
    output logic biquad_first_order,
    output logic [6:0] biquad_code,
    output logic [3:0] highband_pole_code,
    output logic [3:0] highband_zero_code
);
    logic [7:0] tx_slot;
    logic [7:0] rx_slot;
    logic [7:0] tx_gain;
    logic [7:0] rx_gain;
    logic [7:0] echo_cancel_control;
    logic [7:0] biquad_reg;
    logic [7:0] highband_reg;
    logic [7:0] next_tx_slot;
    logic [7:0] next_rx_slot;
    logic [7:0] next_tx_gain;
    logic [7:0] next_rx_gain;
    logic [7:0] next_echo;
    logic [7:0] next_biquad;
    logic [7:0] next_highband;
    logic [7:0] next_read_data;
    logic next_read_valid;

    // The deframer raises instr_write only once the second byte is complete.
    always_comb begin
        next_tx_slot = tx_slot;
        next_rx_slot = rx_slot;
        next_tx_gain = tx_gain;
        next_rx_gain = rx_gain;
        next_echo = echo_cancel_control;
        next_biquad = biquad_reg;
        next_highband = highband_reg;
        if (instr_write) begin
            case (instr_select)
                cgp_pkg::SEL_TX_SLOT: next_tx_slot = instr_data;
                cgp_pkg::SEL_RX_SLOT: next_rx_slot = instr_data;
                cgp_pkg::SEL_TX_GAIN: next_tx_gain = instr_data;
                cgp_pkg::SEL_RX_GAIN: next_rx_gain = instr_data;
                cgp_pkg::SEL_ECHO_CTRL: next_echo = instr_data;
                cgp_pkg::SEL_BIQUAD: next_biquad = instr_data;
                cgp_pkg::SEL_HIGHBAND: next_highband = instr_data;
                default: next_tx_slot = tx_slot;
            endcase
        end
    end

    always_comb begin
        next_read_valid = instr_read;
        case (instr_select)
            cgp_pkg::SEL_TX_SLOT: next_read_data = tx_slot;
            cgp_pkg::SEL_RX_SLOT: next_read_data = rx_slot;
            cgp_pkg::SEL_TX_GAIN: next_read_data = tx_gain;
            cgp_pkg::SEL_RX_GAIN: next_read_data = rx_gain;
            cgp_pkg::SEL_ECHO_CTRL: next_read_data = echo_cancel_control;
            cgp_pkg::SEL_BIQUAD: next_read_data = biquad_reg;
            cgp_pkg::SEL_HIGHBAND: next_read_data = highband_reg;
            default: next_read_data = cgp_pkg::ZERO_BYTE;
        endcase
        if (!instr_read) begin
            next_read_data = read_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_slot <= cgp_pkg::RST_SLOT;
            rx_slot <= cgp_pkg::RST_SLOT;
            tx_gain <= cgp_pkg::RST_GAIN;
            rx_gain <= cgp_pkg::RST_GAIN;
            echo_cancel_control <= cgp_pkg::RST_ECHO;
            biquad_reg <= cgp_pkg::RST_BIQUAD;
            highband_reg <= cgp_pkg::RST_HIGHBAND;
            read_data <= cgp_pkg::ZERO_BYTE;
            read_valid <= 1'b0;
        end else begin
            tx_slot <= next_tx_slot;
            rx_slot <= next_rx_slot;
            tx_gain <= next_tx_gain;
            rx_gain <= next_rx_gain;
            echo_cancel_control <= next_echo;
            biquad_reg <= next_biquad;
            highband_reg <= next_highband;
            read_data <= next_read_data;
            read_valid <= next_read_valid;
        end
    end

    // Receive pins come from the PCM clock world and are synchronised first.
    logic rx_a_meta;
    logic rx_a_sync;
    logic rx_b_meta;
    logic rx_b_sync;
    logic next_tx_a;
    logic next_tx_a_oe;
    logic next_tx_b;
    logic next_tx_b_oe;
    logic next_rx_bit;
    logic next_rx_active;

    always_comb begin
        next_tx_a_oe = tx_slot[cgp_pkg::SLOT_EN_BIT] & ~tx_slot[cgp_pkg::SLOT_PS_BIT];
        next_tx_b_oe = tx_slot[cgp_pkg::SLOT_EN_BIT] & tx_slot[cgp_pkg::SLOT_PS_BIT];
        next_tx_a = next_tx_a_oe & pcm_tx_bit;
        next_tx_b = next_tx_b_oe & pcm_tx_bit;
        next_rx_active = rx_slot[cgp_pkg::SLOT_EN_BIT];
        if (!rx_slot[cgp_pkg::SLOT_EN_BIT]) begin
            next_rx_bit = 1'b0;
        end else if (rx_slot[cgp_pkg::SLOT_PS_BIT]) begin
            next_rx_bit = rx_b_sync;
        end else begin
            next_rx_bit = rx_a_sync;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rx_a_meta <= 1'b0;
            rx_a_sync <= 1'b0;
            rx_b_meta <= 1'b0;
            rx_b_sync <= 1'b0;
            pcm_tx_port_a <= 1'b0;
            pcm_tx_port_a_oe <= 1'b0;
            pcm_tx_port_b <= 1'b0;
            pcm_tx_port_b_oe <= 1'b0;
            pcm_rx_bit <= 1'b0;
            pcm_rx_active <= 1'b0;
        end else begin
            rx_a_meta <= pcm_rx_port_a;
            rx_a_sync <= rx_a_meta;
            rx_b_meta <= pcm_rx_port_b;
            rx_b_sync <= rx_b_meta;
            pcm_tx_port_a <= next_tx_a;
            pcm_tx_port_a_oe <= next_tx_a_oe;
            pcm_tx_port_b <= next_tx_b;
            pcm_tx_port_b_oe <= next_tx_b_oe;
            pcm_rx_bit <= next_rx_bit;
            pcm_rx_active <= next_rx_active;
        end
    end

    // Configuration outputs are straight decodes of the stored registers, except decoder_run, which is tied high.
    assign tx_slot_number = tx_slot[cgp_pkg::SLOT_NUM_MSB:0];
    assign rx_slot_number = rx_slot[cgp_pkg::SLOT_NUM_MSB:0];
    assign transmit_gain_code = tx_gain;
    assign receive_gain_code = rx_gain;
    assign analog_rx_output_enable = (rx_gain != cgp_pkg::ZERO_BYTE);
    assign decoder_run = 1'b1;
    assign cancel_enable = echo_cancel_control[cgp_pkg::ECHO_EN_BIT];
    assign cancel_phase_noninvert = cancel_enable
        & echo_cancel_control[cgp_pkg::ECHO_PHASE_BIT];
    assign highband_enable = cancel_enable
        & echo_cancel_control[cgp_pkg::ECHO_HB_BIT];
    assign cancel_atten_field = echo_cancel_control[cgp_pkg::ECHO_ATTEN_MSB:0];
    assign biquad_enable = cancel_enable
        & (biquad_reg != cgp_pkg::ZERO_BYTE);
    assign biquad_first_order = biquad_enable
        & biquad_reg[cgp_pkg::BIQUAD_MODE_BIT];
    assign biquad_code = biquad_reg[cgp_pkg::BIQUAD_CODE_MSB:0];
    assign highband_pole_code = highband_reg[cgp_pkg::HB_POLE_MSB:cgp_pkg::HB_POLE_LSB];
    assign highband_zero_code = highband_reg[cgp_pkg::HB_ZERO_MSB:0];

    a_tx_gain_write: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_TX_GAIN
        |=> transmit_gain_code == $past(instr_data))
        else $error("transmit gain not loaded");
    a_rx_gain_write: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_RX_GAIN
        |=> receive_gain_code == $past(instr_data))
        else $error("receive gain not loaded");
    a_no_write_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !instr_write |=> $stable(echo_cancel_control) && $stable(tx_gain))
        else $error("register changed without a complete instruction");
    a_rx_mute: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_RX_GAIN
        |=> analog_rx_output_enable == ($past(instr_data) != 8'h0_0) && decoder_run)
        else $error("receive output mute wrong");
    a_cancel_master: assert property (@(posedge clk) disable iff (!reset_n)
        !cancel_enable |-> !highband_enable && !biquad_enable && !cancel_phase_noninvert)
        else $error("cancellation active while master off");
    a_phase_select: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_ECHO_CTRL && instr_data[7]
        |=> cancel_phase_noninvert == $past(instr_data[6]))
        else $error("cancellation phase wrong");
    a_highband_sel: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_ECHO_CTRL && instr_data[7]
        |=> highband_enable == $past(instr_data[5]))
        else $error("highband enable wrong");
    a_atten_field: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_ECHO_CTRL
        |=> cancel_atten_field == $past(instr_data[4:0]))
        else $error("attenuation field wrong");
    a_biquad_bypass: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_BIQUAD && instr_data == 8'h0_0
        |=> !biquad_enable)
        else $error("biquad not bypassed by zero code");
    a_port_exclusive: assert property (@(posedge clk) disable iff (!reset_n)
        !(pcm_tx_port_a_oe && pcm_tx_port_b_oe))
        else $error("both transmit ports driven");
    a_port_select: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_TX_SLOT && instr_data[7:6] == 2'b11
        ##1 !(instr_write && instr_select == cgp_pkg::SEL_TX_SLOT)
        |=> pcm_tx_port_b_oe && !pcm_tx_port_a_oe)
        else $error("transmit port b not selected");
    a_reset_disabled: assert property (@(posedge clk)
        !reset_n |=> !cancel_enable && !biquad_enable)
        else $error("hybrid filter enabled after reset");

    // Port routing is checked against the stored slot registers one cycle on.
    a_tx_port_a: assert property (@(posedge clk) disable iff (!reset_n)
        tx_slot[cgp_pkg::SLOT_EN_BIT] && !tx_slot[cgp_pkg::SLOT_PS_BIT]
        |=> pcm_tx_port_a_oe && !pcm_tx_port_b_oe && pcm_tx_port_a == $past(pcm_tx_bit))
        else $error("transmit port a not driven from the serial bit");
    a_tx_port_b: assert property (@(posedge clk) disable iff (!reset_n)
        tx_slot[cgp_pkg::SLOT_EN_BIT] && tx_slot[cgp_pkg::SLOT_PS_BIT]
        |=> pcm_tx_port_b_oe && !pcm_tx_port_a_oe && pcm_tx_port_b == $past(pcm_tx_bit))
        else $error("transmit port b not driven from the serial bit");
    a_tx_off: assert property (@(posedge clk) disable iff (!reset_n)
        !tx_slot[cgp_pkg::SLOT_EN_BIT]
        |=> !pcm_tx_port_a_oe && !pcm_tx_port_b_oe && !pcm_tx_port_a && !pcm_tx_port_b)
        else $error("transmit port driven while disabled");
    a_rx_route_a: assert property (@(posedge clk) disable iff (!reset_n)
        rx_slot[cgp_pkg::SLOT_EN_BIT] && !rx_slot[cgp_pkg::SLOT_PS_BIT]
        |=> pcm_rx_active && pcm_rx_bit == $past(rx_a_sync))
        else $error("receive bit not taken from port a");
    a_rx_route_b: assert property (@(posedge clk) disable iff (!reset_n)
        rx_slot[cgp_pkg::SLOT_EN_BIT] && rx_slot[cgp_pkg::SLOT_PS_BIT]
        |=> pcm_rx_active && pcm_rx_bit == $past(rx_b_sync))
        else $error("receive bit not taken from port b");
    a_rx_off: assert property (@(posedge clk) disable iff (!reset_n)
        !rx_slot[cgp_pkg::SLOT_EN_BIT]
        |=> !pcm_rx_active && !pcm_rx_bit)
        else $error("receive port active while disabled");
    a_tx_slot_num: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_TX_SLOT
        |=> tx_slot_number == $past(instr_data[5:0]))
        else $error("transmit slot number not loaded");
    a_rx_slot_num: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_RX_SLOT
        |=> rx_slot_number == $past(instr_data[5:0]))
        else $error("receive slot number not loaded");
    a_rx_zero: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_RX_GAIN && instr_data == 8'h0_0
        |=> !analog_rx_output_enable && decoder_run)
        else $error("zero receive gain did not mute the output");
    a_cancel_off: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_ECHO_CTRL && !instr_data[7]
        |=> !cancel_enable && !highband_enable && !biquad_enable && !biquad_first_order)
        else $error("cancellation left on by a master-off write");
    a_biquad_on: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_BIQUAD
        && instr_data != 8'h0_0 && cancel_enable
        |=> biquad_enable)
        else $error("biquad not selected by a nonzero code");
    a_biquad_mode: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_BIQUAD && cancel_enable
        |=> biquad_first_order == $past(instr_data[7])
        && biquad_code == $past(instr_data[6:0]))
        else $error("biquad mode or code wrong");
    a_highband_codes: assert property (@(posedge clk) disable iff (!reset_n)
        instr_write && instr_select == cgp_pkg::SEL_HIGHBAND
        |=> {highband_pole_code, highband_zero_code} == $past(instr_data))
        else $error("highband pole or zero code wrong");
endmodule : cgp_config
`default_nettype wire

/* File: tb/cgp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cgp_host_model #(
    parameter bit SINGLE_PORT = 1'b0
) (
    input wire logic clk,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    output logic instr_write,
    output logic instr_read,
    output logic [7:0] instr_select,
    output logic [7:0] instr_data
);
    initial begin
        instr_write = 1'b0;
        instr_read = 1'b0;
        instr_select = 8'h00;
        instr_data = 8'h00;
    end

    // Gain code for a 0 dBm0 level in volts rms, clamped into the range 1 to 255.
    function automatic logic [7:0] gain_code(input real v, input int ofs);
        int c;
        c = $rtoi(200.0 * $log10(v / $sqrt(0.6)) + ofs + 0.5);
        if (c < 1) c = 1;
        if (c > 255) c = 255;
        return c[7:0];
    endfunction : gain_code

    // One instruction: write, read or both in the same cycle; read data is taken after the edge.
    task automatic xfer(input logic w, input logic r, input logic [7:0] sel,
                        input logic [7:0] d, output logic [7:0] rdat);
        @(posedge clk);
        instr_write <= w;
        instr_read <= r;
        instr_select <= sel;
        // A single-port part only has port a, so the select bit is forced low.
        instr_data <= (SINGLE_PORT && sel <= cgp_pkg::SEL_RX_SLOT) ? (d & 8'hbf) : d;
        @(posedge clk);
        instr_write <= 1'b0;
        instr_read <= 1'b0;
        #1;
        rdat = read_valid ? read_data : 8'hxx;
    endtask : xfer
endmodule : cgp_host_model
`default_nettype wire

/* File: tb/codec_gain_port_hybrid_config_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module codec_gain_port_hybrid_config_tb_top;
    logic clk, reset_n, instr_write, instr_read, read_valid;
    logic [7:0] instr_select, instr_data, read_data, transmit_gain_code, receive_gain_code;
    logic pcm_tx_bit, pcm_rx_port_a, pcm_rx_port_b, pcm_tx_port_a, pcm_tx_port_a_oe;
    logic pcm_tx_port_b, pcm_tx_port_b_oe, pcm_rx_bit, pcm_rx_active;
    logic [5:0] tx_slot_number, rx_slot_number;
    logic analog_rx_output_enable, decoder_run, cancel_enable, cancel_phase_noninvert;
    logic highband_enable, biquad_enable, biquad_first_order;
    logic [4:0] cancel_atten_field;
    logic [6:0] biquad_code;
    logic [3:0] highband_pole_code, highband_zero_code, ha, hb, ht;
    logic [7:0] rd, s, c, e, b, h;
    int mismatches, tests_run;

    cgp_config dut_u (.clk, .reset_n, .instr_write, .instr_read, .instr_select, .instr_data,
        .read_data, .read_valid, .pcm_tx_bit, .pcm_tx_port_a, .pcm_tx_port_a_oe,
        .pcm_tx_port_b, .pcm_tx_port_b_oe, .pcm_rx_port_a, .pcm_rx_port_b, .pcm_rx_bit,
        .pcm_rx_active, .tx_slot_number, .rx_slot_number, .transmit_gain_code,
        .receive_gain_code, .analog_rx_output_enable, .decoder_run, .cancel_enable,
        .cancel_phase_noninvert, .highband_enable, .cancel_atten_field, .biquad_enable,
        .biquad_first_order, .biquad_code, .highband_pole_code, .highband_zero_code);
    cgp_host_model host_u (.clk, .read_data, .read_valid, .instr_write, .instr_read,
        .instr_select, .instr_data);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Serial pins toggle at random every cycle; histories give the expected delayed bits.
    always @(posedge clk) begin
        {pcm_tx_bit, pcm_rx_port_a, pcm_rx_port_b} <= 3'($urandom);
        ht <= {ht[2:0], pcm_tx_bit};
        ha <= {ha[2:0], pcm_rx_port_a};
        hb <= {hb[2:0], pcm_rx_port_b};
    end

    function automatic logic [7:0] port_exp(input logic en, input logic ps);
        return {en & ~ps, en & ps, en, en & ~ps & ht[0], en & ps & ht[0],
                en & (ps ? hb[2] : ha[2]), 2'b00};
    endfunction : port_exp

    function automatic logic [7:0] echo_exp(input logic [7:0] v);
        return {v[7], v[6] & v[7], v[5] & v[7], v[4:0]};
    endfunction : echo_exp

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        #(20000 * 8);
        mismatches++;
        test_done();
    end

    initial begin
        void'($urandom(32'h1cda));
        reset_n = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check(transmit_gain_code, 8'h00);
        check(receive_gain_code, 8'h00);
        check({cancel_enable, biquad_enable, highband_enable, analog_rx_output_enable,
               pcm_tx_port_a_oe, pcm_tx_port_b_oe, pcm_rx_active, decoder_run}, 8'h01);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            s = {i[1], i[0], 6'($urandom)};
            host_u.xfer(1'b1, 1'b0, cgp_pkg::SEL_TX_SLOT, s, rd);
            host_u.xfer(1'b1, 1'b0, cgp_pkg::SEL_RX_SLOT, ~s ^ 8'hc0, rd);
            repeat (4) begin
                @(posedge clk);
                #1;
                check({pcm_tx_port_a_oe, pcm_tx_port_b_oe, pcm_rx_active, pcm_tx_port_a,
                       pcm_tx_port_b, pcm_rx_bit, 2'b00}, port_exp(s[7], s[6]));
            end
            check({tx_slot_number, 2'b00}, {s[5:0], 2'b00});
            check({rx_slot_number, 2'b00}, {~s[5:0], 2'b00});
        end
        $display("test port select done");
        check(host_u.gain_code(0.775, 191), 8'hbf);
        check(host_u.gain_code(0.088, 191), 8'h02);
        check(host_u.gain_code(0.775, 174), 8'hae);
        check(host_u.gain_code(1.71, 174), 8'hf3);
        for (int i = 0; i < 6; i++) begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : (i == 2) ? host_u.gain_code(1.0, 191) :
                (i == 3) ? host_u.gain_code(0.5, 174) : 8'($urandom);
            host_u.xfer(1'b1, 1'b1, cgp_pkg::SEL_TX_GAIN, c, rd);
            check(transmit_gain_code, c);
            host_u.xfer(1'b1, 1'b0, cgp_pkg::SEL_RX_GAIN, ~c, rd);
            check(receive_gain_code, ~c);
            check({analog_rx_output_enable, decoder_run}, {c != 8'hff, 1'b1});
            host_u.xfer(1'b1, 1'b1, cgp_pkg::SEL_TX_GAIN, ~c, rd);
            check(rd, c);
            host_u.xfer(1'b0, 1'b1, cgp_pkg::SEL_RX_GAIN, 8'h00, rd);
            check(rd, ~c);
        end
        $display("test gains done");
        for (int i = 0; i < 12; i++) begin
            e = (i == 0) ? 8'hff : (i == 1) ? 8'h18 : (i == 2) ? 8'h7f : 8'($urandom);
            b = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($urandom);
            h = 8'($urandom);
            host_u.xfer(1'b1, 1'b0, cgp_pkg::SEL_ECHO_CTRL, e, rd);
            host_u.xfer(1'b1, 1'b0, cgp_pkg::SEL_BIQUAD, b, rd);
            host_u.xfer(1'b1, 1'b0, cgp_pkg::SEL_HIGHBAND, h, rd);
            check({cancel_enable, cancel_phase_noninvert, highband_enable, cancel_atten_field},
                  echo_exp(e));
            check({biquad_enable, biquad_code}, {e[7] & (b != 8'h00), b[6:0]});
            check({biquad_first_order, 7'h00}, {e[7] & (b != 8'h00) & b[7], 7'h00});
            check({highband_pole_code, highband_zero_code}, h);
            host_u.xfer(1'b0, 1'b1, cgp_pkg::SEL_ECHO_CTRL, 8'h00, rd);
            check(rd, e);
        end
        $display("test hybrid balance done");
        host_u.xfer(1'b1, 1'b0, 8'h07, 8'haa, rd);
        host_u.xfer(1'b0, 1'b1, 8'h07, 8'h00, rd);
        check(rd, 8'h00);
        check(transmit_gain_code, ~c);
        $display("test unmapped done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check({cancel_enable, biquad_enable, highband_enable, cancel_atten_field}, 8'h00);
        check(transmit_gain_code, 8'h00);
        $display("test mid-run reset done");
        test_done();
    end
endmodule : codec_gain_port_hybrid_config_tb_top
`default_nettype wire
